// [logic/mpgs_cfg.svh]
// timing constants and reset values for the power-good sequencer
`ifndef MPGS_CFG_SVH
`define MPGS_CFG_SVH
`define MPGS_CLK_HZ        25000000
`define MPGS_SEQ_STEP_US   1000
`define MPGS_SEQ_STEP_CYC  ((`MPGS_CLK_HZ / 1000000) * `MPGS_SEQ_STEP_US)
`define MPGS_BTN_MIN_NS    1000
`define MPGS_BTN_MIN_CYC   ((`MPGS_BTN_MIN_NS + 39) / 40)
`define MPGS_CNT_W         16
`define MPGS_ON_RESET      1'b0
`endif

// [logic/mpgs_pkg.sv]
// types of the power-good sequencer
package mpgs_pkg;
  typedef enum logic [4:0] {
    MPGS_OFF     = 5'h01,
    MPGS_RAMP    = 5'h02,
    MPGS_WAIT_PG = 5'h04,
    MPGS_RUN     = 5'h08,
    MPGS_DOWN    = 5'h10
  } mpgs_state_t;

  typedef struct packed {
    logic supply_good;
    logic button_n;
  } mpgs_pins_t;

  typedef struct packed {
    logic sleep_state3_n;
    logic sleep_state4_n;
    logic sleep_state5_n;
    logic module_reset_n;
  } mpgs_ctl_t;
endpackage

// [logic/mpgs_sync.sv]
// two-flop synchroniser for the power-control pins
`timescale 1ns/100ps
module mpgs_sync
  import mpgs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire mpgs_pins_t pins_async,
  output mpgs_pins_t      pins_sync
);
  // idle levels: supply not good, button released
  mpgs_pins_t stage1;
  mpgs_pins_t next_stage1;

  always_comb begin
    next_stage1 = pins_async;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1    <= '{supply_good: 1'b0, button_n: 1'b1};
      pins_sync <= '{supply_good: 1'b0, button_n: 1'b1};
    end else begin
      stage1    <= next_stage1;
      pins_sync <= stage1;
    end
  end
endmodule

// [logic/mpgs_top.sv]
// power-good gated power-up sequencer with button toggle
`timescale 1ns/100ps
`include "mpgs_cfg.svh"

module mpgs_top
  import mpgs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic supply_good_in,
  input  wire logic power_button_in_n,
  input  wire logic auto_power_on,
  output logic      sleep_state3_out_n,
  output logic      sleep_state4_out_n,
  output logic      sleep_state5_out_n,
  output logic      module_reset_out_n,
  output logic      power_on
);
  mpgs_pins_t  pins_raw;
  mpgs_pins_t  pins_sync;
  mpgs_state_t state;
  mpgs_state_t next_state;
  logic [`MPGS_CNT_W-1:0] cnt;
  logic [`MPGS_CNT_W-1:0] next_cnt;
  logic [`MPGS_CNT_W-1:0] btn_cnt;
  logic [`MPGS_CNT_W-1:0] next_btn_cnt;
  logic        btn_latched;
  logic        next_btn_latched;
  logic        boot_done;
  logic        next_boot_done;
  logic        press;
  mpgs_ctl_t   ctl;
  mpgs_ctl_t   next_ctl;

  ////////////////////////////////////////////////////////////////////////////
  // an undriven supply good pin is pulled high on the module, so a floating
  // pin reads as good and the module still boots
  mpgs_sync u_sync (
    .mclk       (mclk),
    .resetn     (resetn),
    .pins_async (pins_raw),
    .pins_sync  (pins_sync)
  );

  // raw pins gathered into one carrier before the synchroniser
  always_comb begin
    pins_raw.supply_good = supply_good_in;
    pins_raw.button_n    = power_button_in_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // press accepted once held low for a minimum time; one toggle per press
  always_comb begin
    next_btn_cnt     = btn_cnt;
    next_btn_latched = btn_latched;
    press            = 1'b0;
    if (pins_sync.button_n) begin
      next_btn_cnt     = '0;
      next_btn_latched = 1'b0;
    end else if (!btn_latched) begin
      if (btn_cnt >= `MPGS_CNT_W'(`MPGS_BTN_MIN_CYC - 1)) begin
        press            = 1'b1;
        next_btn_latched = 1'b1;
      end else begin
        next_btn_cnt = btn_cnt + `MPGS_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      btn_cnt     <= '0;
      btn_latched <= 1'b0;
    end else begin
      btn_cnt     <= next_btn_cnt;
      btn_latched <= next_btn_latched;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_boot_done = boot_done;
    case (state)
      MPGS_OFF: begin
        next_cnt = '0;
        // auto power-on is taken once after reset, then only the button counts
        if (press || (auto_power_on && !boot_done)) begin
          next_state     = MPGS_RAMP;
          next_boot_done = 1'b1;
        end else begin
          next_boot_done = 1'b1;
        end
      end
      MPGS_RAMP: begin
        // main rails ramping; settle one step before looking at supply good
        if (press) begin
          next_state = MPGS_DOWN;
          next_cnt   = '0;
        end else if (cnt >= `MPGS_CNT_W'(`MPGS_SEQ_STEP_CYC - 1)) begin
          next_state = MPGS_WAIT_PG;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + `MPGS_CNT_W'(1);
        end
      end
      MPGS_WAIT_PG: begin
        if (press) begin
          next_state = MPGS_DOWN;
        end else if (pins_sync.supply_good) begin
          next_state = MPGS_RUN;
        end
      end
      MPGS_RUN: begin
        if (press) begin
          next_state = MPGS_DOWN;
          next_cnt   = '0;
        end else if (!pins_sync.supply_good) begin
          next_state = MPGS_WAIT_PG;
        end
      end
      MPGS_DOWN: begin
        // hold reset while rails fall so a fast re-press cannot glitch them
        if (cnt >= `MPGS_CNT_W'(`MPGS_SEQ_STEP_CYC - 1)) begin
          next_state = MPGS_OFF;
          next_cnt   = '0;
        end else begin
          next_cnt = cnt + `MPGS_CNT_W'(1);
        end
      end
      default: begin
        next_state = MPGS_OFF;
        next_cnt   = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs registered from the next state
  always_comb begin
    next_ctl.module_reset_n = (next_state == MPGS_RUN);
    // no S3: all three sleep outputs only mirror main supply on or off
    next_ctl.sleep_state3_n = (next_state == MPGS_RAMP) || (next_state == MPGS_WAIT_PG)
                              || (next_state == MPGS_RUN);
    next_ctl.sleep_state4_n = next_ctl.sleep_state3_n;
    next_ctl.sleep_state5_n = next_ctl.sleep_state3_n;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state     <= MPGS_OFF;
      cnt       <= '0;
      boot_done <= `MPGS_ON_RESET;
      ctl       <= '0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      boot_done <= next_boot_done;
      ctl       <= next_ctl;
    end
  end

  always_comb begin
    sleep_state3_out_n = ctl.sleep_state3_n;
    sleep_state4_out_n = ctl.sleep_state4_n;
    sleep_state5_out_n = ctl.sleep_state5_n;
    module_reset_out_n = ctl.module_reset_n;
    power_on           = ctl.sleep_state3_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pg_low_in_run;
    (state == MPGS_RUN) && !pins_sync.supply_good;
  endsequence

  property p_reset_needs_pg;
    @(posedge mclk) disable iff (!resetn)
      (module_reset_out_n && !$past(module_reset_out_n)) |-> $past(pins_sync.supply_good);
  endproperty
  a_reset_needs_pg: assert property (p_reset_needs_pg) else $error("reset released without supply good");

  property p_pg_drop_resets;
    @(posedge mclk) disable iff (!resetn)
      s_pg_low_in_run ##0 !press |=> !module_reset_out_n;
  endproperty
  a_pg_drop_resets: assert property (p_pg_drop_resets) else $error("reset not held on supply good low");

  property p_reset_low_when_pg_low;
    @(posedge mclk) disable iff (!resetn)
      (!pins_sync.supply_good)[*2] |-> ##1 !module_reset_out_n;
  endproperty
  a_reset_low_when_pg_low: assert property (p_reset_low_when_pg_low) else $error("module out of reset, pg low");

  property p_wait_to_run;
    @(posedge mclk) disable iff (!resetn)
      (state == MPGS_WAIT_PG && pins_sync.supply_good && !press) |=> state == MPGS_RUN && module_reset_out_n;
  endproperty
  a_wait_to_run: assert property (p_wait_to_run) else $error("sequencing did not proceed on supply good");

  property p_s3_mirrors;
    @(posedge mclk) disable iff (!resetn)
      sleep_state3_out_n == sleep_state5_out_n && power_on == sleep_state3_out_n;
  endproperty
  a_s3_mirrors: assert property (p_s3_mirrors) else $error("S3 output not mirroring supply");

  property p_reset_implies_s3;
    @(posedge mclk) disable iff (!resetn)
      module_reset_out_n |-> !sleep_state3_out_n == 1'b0;
  endproperty
  a_reset_implies_s3: assert property (p_reset_implies_s3) else $error("running with supply off");

  property p_press_off_starts;
    @(posedge mclk) disable iff (!resetn)
      (state == MPGS_OFF && press) |=> state == MPGS_RAMP ##1 sleep_state3_out_n;
  endproperty
  a_press_off_starts: assert property (p_press_off_starts) else $error("press did not power on");

  property p_press_run_stops;
    @(posedge mclk) disable iff (!resetn)
      (state == MPGS_RUN && press) |=> state == MPGS_DOWN ##1 !sleep_state3_out_n;
  endproperty
  a_press_run_stops: assert property (p_press_run_stops) else $error("press did not power off");

  property p_one_press;
    @(posedge mclk) disable iff (!resetn)
      press |=> !press;
  endproperty
  a_one_press: assert property (p_one_press) else $error("press toggled twice");

  property p_sync_delay;
    @(posedge mclk) disable iff (!resetn)
      $rose(pins_sync.supply_good) |-> $past(supply_good_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("supply good not two-flop synchronised");
endmodule

// [test/mpgs_carrier_model.sv]
// carrier supply model driving the power-good line
`timescale 1ns/100ps
module mpgs_carrier_model #(
  parameter int GOOD_DLY = 40
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic sleep_state5_out_n,
  input  wire logic drive_en,
  input  wire logic hold_low,
  output logic      supply_good_in
);
  int   cnt;
  logic pull_low;

  // short stand-in for the long carrier settle delay
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      cnt <= 0;
    else if (!sleep_state5_out_n)
      cnt <= 0;
    else if (cnt < GOOD_DLY)
      cnt <= cnt + 1;
  end

  assign pull_low = drive_en && (hold_low || !sleep_state5_out_n || cnt < GOOD_DLY);
  // released line is driven high as a stand-in for the pull-up, never left floating
  assign supply_good_in = pull_low ? 1'h0 : 1'h1;
endmodule

// [test/tb_mpgs_top.sv]
// self-checking bench for the power-good sequencer
`timescale 1ns/100ps
module tb_mpgs_top;
  logic mclk;
  logic resetn;
  logic power_button_in_n;
  logic auto_power_on;
  logic drive_en;
  logic hold_low;
  logic supply_good_in;
  logic s3_n;
  logic s4_n;
  logic s5_n;
  logic rst_n;
  logic power_on;
  int   error_cnt;
  int   compares;
  int   seed;

  mpgs_top i_mpgs_top (
    .mclk               (mclk),
    .resetn             (resetn),
    .supply_good_in     (supply_good_in),
    .power_button_in_n  (power_button_in_n),
    .auto_power_on      (auto_power_on),
    .sleep_state3_out_n (s3_n),
    .sleep_state4_out_n (s4_n),
    .sleep_state5_out_n (s5_n),
    .module_reset_out_n (rst_n),
    .power_on           (power_on)
  );

  mpgs_carrier_model i_mpgs_carrier_model (
    .mclk               (mclk),
    .resetn             (resetn),
    .sleep_state5_out_n (s5_n),
    .drive_en           (drive_en),
    .hold_low           (hold_low),
    .supply_good_in     (supply_good_in)
  );

  task automatic check(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %b seen %b", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic check_outs(input logic pwr, input logic rdy);
    check("sleep3", pwr, s3_n);
    check("sleep4", pwr, s4_n);
    check("sleep5", pwr, s5_n);
    check("power_on", pwr, power_on);
    check("reset_n", rdy, rst_n);
  endtask

  task automatic wait_for(input logic rst_side, input logic val, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ((rst_side ? rst_n : power_on) === val)
        break;
      @(negedge mclk);
    end
  endtask

  task automatic press(input int len);
    power_button_in_n = 1'h0;
    repeat (len) @(negedge mclk);
    power_button_in_n = 1'h1;
    @(negedge mclk);
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // whole run is about 76000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    $display("[ERR] watchdog expected done seen hang");
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    seed = 32'hfdb1;
    resetn = 1'h0;
    power_button_in_n = 1'h1;
    auto_power_on = 1'h0;
    drive_en = 1'h1;
    hold_low = 1'h0;
    repeat (5) @(negedge mclk);
    resetn = 1'h1;
    // a glitch shorter than the minimum press must not power up
    press(1 + ($unsigned($random(seed)) % 8));
    repeat (100) @(negedge mclk);
    check_outs(1'h0, 1'h0);
    $display("test idle done");
    hold_low = 1'h1;
    press(30 + ($unsigned($random(seed)) % 16));
    wait_for(1'h0, 1'h1, 40);
    check_outs(1'h1, 1'h0);
    repeat (25100) @(negedge mclk);
    check("reset_n", 1'h0, rst_n);
    hold_low = 1'h0;
    wait_for(1'h1, 1'h1, 8);
    check_outs(1'h1, 1'h1);
    $display("test power up done");
    hold_low = 1'h1;
    repeat (8) @(negedge mclk);
    check_outs(1'h1, 1'h0);
    hold_low = 1'h0;
    wait_for(1'h1, 1'h1, 8);
    check("reset_n", 1'h1, rst_n);
    $display("test supply drop done");
    press(30 + ($unsigned($random(seed)) % 16));
    wait_for(1'h0, 1'h0, 40);
    check_outs(1'h0, 1'h0);
    // presses during power-down are ignored
    repeat (100) @(negedge mclk);
    press(30);
    repeat (25100) @(negedge mclk);
    check_outs(1'h0, 1'h0);
    $display("test power off done");
    // a second press while the rails still ramp aborts the power-up
    press(30);
    check_outs(1'h1, 1'h0);
    repeat (100) @(negedge mclk);
    press(30);
    check_outs(1'h0, 1'h0);
    $display("test press in ramp done");
    drive_en = 1'h0;
    auto_power_on = 1'h1;
    resetn = 1'h0;
    repeat (5) @(negedge mclk);
    resetn = 1'h1;
    wait_for(1'h1, 1'h1, 25100);
    check_outs(1'h1, 1'h1);
    $display("test floating supply good done");
    end_of_test();
  end
endmodule
